// [logic/sef_map.vh]
// Function
// R1 - Deselect puts device in standby, output released
// R2 - Deselected device ignores serial input entirely
// R3 - Select falling starts, rising ends operation
// R4 - Standby waits for self-timed write completion
// R5 - Serial output changes only on clock falling
// R6 - Serial input sampled on clock rising edge
// R7 - Pause entered while clock low, state kept
// R8 - Resume while clock low; paused edges ignored
// R9 - Paused: input ignored, output released
// R10 - Pause only while selected and sequence running
// R11 - Guard low refuses writes to protected blocks
// R12 - Guard low with enable refuses status writes
// R13 - Most significant bit first; first byte opcode
// R14 - Enable clear makes guard ignored for status
// R15 - Deselect while paused aborts, clears write permit
// R16 - Unknown opcode: ignore rest, output released
// R17 - Works with clock idling low or high
`ifndef SEF_MAP_VH
`define SEF_MAP_VH
`define SEF_OP_WRSR 8'h01
`define SEF_OP_WRITE 8'h02
`define SEF_OP_READ 8'h03
`define SEF_OP_WRDI 8'h04
`define SEF_OP_RDSR 8'h05
`define SEF_OP_WREN 8'h06
`define SEF_OP_WRITE2 8'h07
`define SEF_OP_LPWP 8'h08
`define SEF_BIT_LAST 3'h7
`define SEF_BP_NONE 2'h0
`define SEF_BP_UPQ 2'h1
`define SEF_BP_UPH 2'h2
`define SEF_BP_ALL 2'h3
`define SEF_ADDR_W 18
`define SEF_SYNC_RST 2'h0
`define SEF_SYNC_SET 2'h3
`endif

// [logic/sef_buf2.v]
module sef_buf2 #(
    parameter W = 8
) (
    // Clock, reset, enable
    input wire ref_clk,
    input wire rst,
    input wire ce,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem_r [0:1];
    reg wp_r;
    reg rp_r;
    reg [1:0] cnt_r;
    wire push;
    wire pop;

    assign in_ready = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data = mem_r[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge ref_clk) begin
        if (rst) begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'h0;
        end else if (ce) begin
            if (push) begin
                mem_r[wp_r] <= in_data;
                wp_r <= ~wp_r;
            end
            if (pop) begin
                rp_r <= ~rp_r;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 2'h1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 2'h1;
            end
        end
    end
endmodule

// [logic/sef_frontend.v]
`include "sef_map.vh"

module sef_frontend (
    // Clock, reset, enable
    input wire ref_clk,
    input wire rst,
    input wire ce,
    // Serial pins
    input wire sel_n,
    input wire sclk,
    input wire sdi,
    output reg sdo,
    output reg sdo_oe,
    input wire pause_input_n,
    input wire write_guard_n,
    // Status bits from array control
    input wire guard_pin_enable,
    input wire [1:0] block_protect,
    input wire write_busy,
    // Read data into serializer
    input wire [7:0] tx_data,
    input wire tx_valid,
    output reg tx_take,
    // Received bytes to core
    output reg [7:0] rx_data,
    output reg rx_valid,
    input wire rx_ready,
    output reg rx_first,
    // Status outputs
    output reg [7:0] opcode,
    output reg op_active,
    output reg standby,
    output reg paused,
    output reg write_permit_latch,
    output reg status_write_refused,
    output reg array_write_refused,
    output reg abort_pulse,
    output reg rx_overflow
);
    localparam ST_IDLE = 4'h1;
    localparam ST_OPC = 4'h2;
    localparam ST_DATA = 4'h4;
    localparam ST_DEAD = 4'h8;

    // Two-stage input synchronisers
    reg [1:0] cs_s, ck_s, di_s, ho_s, wp_s;
    reg ck_d, cs_d;
    reg [3:0] st_r;
    reg [2:0] bit_r;
    reg [7:0] sh_r;
    reg [7:0] txs_r;
    reg txl_r;
    reg hold_r;
    reg bval_r;
    reg [7:0] bdat_r;
    reg bfirst_r;
    reg wait_r;

    wire cs_n = cs_s[1];
    wire ck = ck_s[1];
    wire ck_rise = ck && !ck_d; // R17
    wire ck_fall = !ck && ck_d; // R17
    wire cs_fall = !cs_n && cs_d; // R3
    wire cs_rise = cs_n && !cs_d; // R3
    wire busy_seq = (st_r == ST_OPC) || (st_r == ST_DATA);
    // Pause state as it will be after this cycle, except in a deselect cycle, which clears it
    wire hold_nxt = (!ck && busy_seq && !cs_n) ? !ho_s[1] : hold_r;
    wire [7:0] byte_in = {sh_r[6:0], di_s[1]};
    wire guard = !wp_s[1];
    wire bq_ready;
    wire bq_valid;
    wire [8:0] bq_data;
    wire out_sel;

    // Opcode flag travels with its byte through the buffer
    sef_buf2 #(.W(9)) u_buf (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .in_valid(bval_r),
        .in_ready(bq_ready),
        .in_data({bfirst_r, bdat_r}),
        .out_valid(bq_valid),
        .out_ready(rx_ready || !rx_valid),
        .out_data(bq_data)
    );

    assign out_sel = (opcode == `SEF_OP_READ) || (opcode == `SEF_OP_RDSR);

    ////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        if (rst) begin
            cs_s <= `SEF_SYNC_SET;
            ho_s <= `SEF_SYNC_SET;
            wp_s <= `SEF_SYNC_SET;
            ck_s <= `SEF_SYNC_RST;
            di_s <= `SEF_SYNC_RST;
            ck_d <= 1'b0;
            cs_d <= 1'b1;
        end else if (ce) begin
            cs_s <= {cs_s[0], sel_n};
            ck_s <= {ck_s[0], sclk};
            di_s <= {di_s[0], sdi};
            ho_s <= {ho_s[0], pause_input_n};
            wp_s <= {wp_s[0], write_guard_n};
            ck_d <= ck_s[1];
            cs_d <= cs_s[1];
        end
    end

    ////////////////////////////////////////////////////////////////
    // Serial sequencer
    always @(posedge ref_clk) begin
        if (rst) begin
            st_r <= ST_IDLE;
            bit_r <= 3'h0;
            sh_r <= 8'h00;
            txs_r <= 8'h00;
            txl_r <= 1'b0;
            hold_r <= 1'b0;
            bval_r <= 1'b0;
            bdat_r <= 8'h00;
            bfirst_r <= 1'b0;
            wait_r <= 1'b0;
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
            tx_take <= 1'b0;
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
            rx_first <= 1'b0;
            opcode <= 8'h00;
            op_active <= 1'b0;
            standby <= 1'b1;
            paused <= 1'b0;
            write_permit_latch <= 1'b0;
            status_write_refused <= 1'b0;
            array_write_refused <= 1'b0;
            abort_pulse <= 1'b0;
            rx_overflow <= 1'b0;
        end else if (ce) begin
            tx_take <= 1'b0;
            abort_pulse <= 1'b0;
            if (bval_r && bq_ready) begin
                bval_r <= 1'b0;
            end
            if (bq_valid && (rx_ready || !rx_valid)) begin
                rx_valid <= 1'b1;
                rx_data <= bq_data[7:0];
                rx_first <= bq_data[8];
            end else if (rx_ready) begin
                rx_valid <= 1'b0;
            end
            // Self-timed write keeps device out of standby
            if (wait_r && !write_busy) begin
                wait_r <= 1'b0;
                standby <= 1'b1; // R4
            end
            // Pause only mid-sequence, toggled while clock low
            hold_r <= hold_nxt; // R7 R8 R10
            paused <= hold_nxt;
            status_write_refused <= guard && guard_pin_enable; // R12 R14
            array_write_refused <= guard && (block_protect != `SEF_BP_NONE); // R11
            if (cs_rise) begin
                st_r <= ST_IDLE; // R1 R3
                sdo_oe <= 1'b0;
                op_active <= 1'b0;
                hold_r <= 1'b0;
                paused <= 1'b0;
                if (hold_r) begin
                    write_permit_latch <= 1'b0; // R15
                    abort_pulse <= 1'b1;
                end
                if (write_busy) begin
                    wait_r <= 1'b1; // R4
                end else begin
                    standby <= 1'b1; // R1
                end
            end else if (cs_fall) begin
                st_r <= ST_OPC; // R3 R13
                bit_r <= 3'h0;
                standby <= 1'b0;
                wait_r <= 1'b0;
                op_active <= 1'b1;
            end else if (cs_n) begin
                sdo_oe <= 1'b0; // R1 R2
            end else if (hold_nxt) begin
                sdo_oe <= 1'b0; // R9
            end else begin
                case (st_r)
                    ST_OPC, ST_DATA: begin
                        if (ck_rise) begin
                            sh_r <= byte_in; // R6 R13
                            bit_r <= bit_r + 3'h1;
                            if (bit_r == `SEF_BIT_LAST) begin
                                if (bq_ready) begin
                                    bval_r <= 1'b1;
                                    bdat_r <= byte_in;
                                    bfirst_r <= (st_r == ST_OPC); // R13
                                end else begin
                                    rx_overflow <= 1'b1;
                                end
                                if (st_r == ST_OPC) begin
                                    opcode <= byte_in;
                                    st_r <= ST_DATA;
                                    if (byte_in == `SEF_OP_WREN) begin
                                        write_permit_latch <= 1'b1;
                                    end else if (byte_in == `SEF_OP_WRDI) begin
                                        write_permit_latch <= 1'b0;
                                    end else if (byte_in != `SEF_OP_WRSR &&
                                                 byte_in != `SEF_OP_WRITE &&
                                                 byte_in != `SEF_OP_WRITE2 &&
                                                 byte_in != `SEF_OP_READ &&
                                                 byte_in != `SEF_OP_RDSR &&
                                                 byte_in != `SEF_OP_LPWP) begin
                                        st_r <= ST_DEAD; // R16
                                    end
                                end
                            end
                        end
                        if (ck_fall && st_r == ST_DATA && out_sel) begin
                            sdo_oe <= 1'b1; // R5
                            if (bit_r == 3'h0) begin
                                sdo <= tx_data[7]; // R13
                                txs_r <= {tx_data[6:0], 1'b0};
                                tx_take <= tx_valid;
                                txl_r <= 1'b1;
                            end else begin
                                sdo <= txs_r[7]; // R5
                                txs_r <= {txs_r[6:0], 1'b0};
                            end
                        end
                    end
                    ST_DEAD: begin
                        sdo_oe <= 1'b0; // R16
                    end
                    default: begin
                        sdo_oe <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule

// [testbench/sef_chk.sv]
module sef_chk (
    // Clock, reset, enable
    input wire ref_clk,
    input wire rst,
    input wire ce,
    // Pins
    input wire sel_n,
    input wire sclk,
    input wire sdo,
    input wire sdo_oe,
    // Core side
    input wire write_busy,
    input wire guard_pin_enable,
    input wire rx_valid,
    // Status outputs
    input wire op_active,
    input wire standby,
    input wire paused,
    input wire write_permit_latch,
    input wire status_write_refused,
    input wire abort_pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst || !ce);
    sequence idle_s;
        sel_n [*5];
    endsequence
    sequence idle_long_s;
        idle_s ##0 sel_n [*8];
    endsequence
    desel_quiet_a: assert property (idle_s |-> !sdo_oe)
        else $error("output driven while deselected");
    desel_deaf_a: assert property (idle_long_s |-> !$rose(rx_valid))
        else $error("byte taken while deselected");
    sel_start_a: assert property ($fell(sel_n) ##1 !sel_n |-> ##[1:4] op_active)
        else $error("select not seen");
    sel_end_a: assert property ($rose(sel_n) |-> ##[2:5] !op_active)
        else $error("deselect not seen");
    busy_wait_a: assert property (!standby && write_busy |=> !standby)
        else $error("standby during write");
    out_fall_a: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo) |-> !$past(sclk, 3))
        else $error("output moved off falling edge");
    pause_quiet_a: assert property (paused |-> !sdo_oe)
        else $error("output driven while paused");
    pause_sel_a: assert property ($rose(paused) |-> op_active)
        else $error("pause while deselected");
    abort_clear_a: assert property (abort_pulse |-> ##[0:1] !write_permit_latch)
        else $error("permit kept after abort");
    guard_off_a: assert property (!guard_pin_enable && !$past(guard_pin_enable) |-> !status_write_refused)
        else $error("status refused with guard off");
endmodule
////////////////////////////////////////////////////////////////
bind sef_frontend sef_chk sef_chk_i (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .sel_n(sel_n),
    .sclk(sclk),
    .sdo(sdo),
    .sdo_oe(sdo_oe),
    .write_busy(write_busy),
    .guard_pin_enable(guard_pin_enable),
    .rx_valid(rx_valid),
    .op_active(op_active),
    .standby(standby),
    .paused(paused),
    .write_permit_latch(write_permit_latch),
    .status_write_refused(status_write_refused),
    .abort_pulse(abort_pulse)
);

// [testbench/sef_master.sv]
module sef_master (
    // Device side
    input wire ref_clk,
    input wire sdo,
    input wire sdo_oe,
    // Pins driven
    output logic sel_n,
    output logic sclk,
    output logic sdi,
    output logic pause_input_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic cpol = 1'b0;
    logic [7:0] q;
    initial begin
        sel_n = 1;
        sclk = 0;
        sdi = 0;
        pause_input_n = 1;
    end
    task sel(input logic m);
        @(posedge ref_clk) #1;
        cpol = m;
        sclk = m;
        #200 sel_n = 0;
        #200;
    endtask
    // Top n bits, set while low, read mid high phase
    task bits(input logic [7:0] d, input int n);
        for (int i = 0; i < n; i++) begin
            sclk = 0;
            sdi = d[7 - i];
            #200 sclk = 1;
            #100 q = {q[6:0], sdo_oe ? sdo : 1'bx};
            #100;
        end
    endtask
    task desel();
        sclk = cpol;
        #200 sel_n = 1;
        sdi = ~sdi;
        #200;
    endtask
    task hold(input logic v);
        sclk = 0;
        #100 pause_input_n = v;
        #100;
    endtask
    task jog();
        repeat (2) begin
            sdi = ~sdi;
            #200 sclk = 1;
            #200 sclk = 0;
        end
    endtask
endmodule

// [testbench/testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 0, rst = 1, ce = 1, write_guard_n = 1, guard_pin_enable = 0;
    logic write_busy = 0, tx_valid = 1, rx_ready = 1;
    logic [1:0] block_protect = 2'h3;
    logic [7:0] tx_data = 8'hc6;
    wire sel_n, sclk, sdi, sdo, sdo_oe, pause_input_n, tx_take, rx_valid, rx_first;
    wire op_active, standby, paused, write_permit_latch, status_write_refused;
    wire array_write_refused, abort_pulse, rx_overflow;
    wire [7:0] rx_data, opcode;
    int failures = 0, checked = 0, cyc = 0, aborts = 0, takes = 0, take_base = 0;
    logic [8:0] rxq[$];
    sef_frontend sef_frontend_i (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .sel_n(sel_n),
        .sclk(sclk),
        .sdi(sdi),
        .sdo(sdo),
        .sdo_oe(sdo_oe),
        .pause_input_n(pause_input_n),
        .write_guard_n(write_guard_n),
        .guard_pin_enable(guard_pin_enable),
        .block_protect(block_protect),
        .write_busy(write_busy),
        .tx_data(tx_data),
        .tx_valid(tx_valid),
        .tx_take(tx_take),
        .rx_data(rx_data),
        .rx_valid(rx_valid),
        .rx_ready(rx_ready),
        .rx_first(rx_first),
        .opcode(opcode),
        .op_active(op_active),
        .standby(standby),
        .paused(paused),
        .write_permit_latch(write_permit_latch),
        .status_write_refused(status_write_refused),
        .array_write_refused(array_write_refused),
        .abort_pulse(abort_pulse),
        .rx_overflow(rx_overflow)
    );
    sef_master sef_master_i (
        .ref_clk(ref_clk),
        .sdo(sdo),
        .sdo_oe(sdo_oe),
        .sel_n(sel_n),
        .sclk(sclk),
        .sdi(sdi),
        .pause_input_n(pause_input_n)
    );
    initial forever #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (abort_pulse) aborts++;
        if (tx_take) takes++;
        if (rx_valid && rx_ready) rxq.push_back({rx_first, rx_data});
        if (cyc == 20000) begin
            failures++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////
    task chk(input logic [8:0] got, input logic [8:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task pop(input logic [8:0] e);
        chk(rxq.size() > 0 ? rxq.pop_front() : 9'bx, e, "rx byte");
    endtask
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task close_out();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        tick(8);
        rst = 0;
        tick(4);
        chk(standby, 1, "reset standby");
        for (int c = 0; c < 2; c++) begin
            tx_data = c[0] ? 8'h39 : 8'hc6;
            tx_valid = !c[0];
            take_base = takes;
            sef_master_i.sel(c[0]);
            sef_master_i.bits(8'h05, 8);
            sef_master_i.bits(8'h00, 8);
            chk(sef_master_i.q, c[0] ? 8'h39 : 8'hc6, "read byte");
            sef_master_i.desel();
            chk(sdo_oe, 0, "released");
            chk(takes != take_base, tx_valid, "take pulse");
            pop(9'h105);
            rxq.delete();
        end
        $display("done: modes");
        sef_master_i.sel(0);
        sef_master_i.bits(8'h06, 4);
        sef_master_i.hold(0);
        tick(4);
        chk(paused, 1, "paused");
        chk(sdo_oe, 0, "paused out");
        sef_master_i.jog();
        sef_master_i.hold(1);
        tick(4);
        chk(paused, 0, "resumed");
        sef_master_i.bits(8'h60, 4);
        sef_master_i.desel();
        pop(9'h106);
        chk(write_permit_latch, 1, "permit set");
        $display("done: pause");
        sef_master_i.sel(0);
        sef_master_i.bits(8'h02, 4);
        sef_master_i.hold(0);
        sef_master_i.desel();
        sef_master_i.hold(1);
        chk(aborts, 1, "abort pulse");
        chk(write_permit_latch, 0, "permit cleared");
        rxq.delete();
        $display("done: abort");
        sef_master_i.sel(0);
        sef_master_i.bits(8'hff, 8);
        sef_master_i.bits(8'h05, 8);
        chk(sdo_oe, 0, "unknown op out");
        sef_master_i.desel();
        pop(9'h1ff);
        chk(rxq.size() == 0, 1, "unknown op rx");
        rxq.delete();
        $display("done: unknown");
        rx_ready = 0;
        sef_master_i.sel(0);
        sef_master_i.bits(8'h02, 8);
        sef_master_i.bits(8'ha5, 8);
        sef_master_i.bits(8'h3c, 8);
        sef_master_i.bits(8'h5a, 8);
        sef_master_i.desel();
        chk(rx_overflow, 1, "overflow");
        chk(opcode, 8'h02, "opcode");
        rx_ready = 1;
        tick(4);
        pop(9'h102);
        pop(9'h0a5);
        pop(9'h03c);
        $display("done: stall");
        for (int g = 0; g < 2; g++) begin
            guard_pin_enable = g[0];
            block_protect = g[0] ? 2'h3 : 2'h0;
            write_guard_n = 0;
            sef_master_i.sel(0);
            sef_master_i.bits(8'h01, 8);
            sef_master_i.bits(8'h80, 8);
            chk(status_write_refused, g[0], "status guard");
            chk(array_write_refused, g[0], "array guard");
            sef_master_i.desel();
            write_guard_n = 1;
        end
        $display("done: guard");
        write_busy = 1;
        sef_master_i.sel(0);
        sef_master_i.bits(8'h06, 8);
        sef_master_i.desel();
        tick(4);
        chk(standby, 0, "busy standby");
        write_busy = 0;
        tick(6);
        chk(standby, 1, "standby");
        $display("done: busy");
        ce = 0;
        sef_master_i.sel(0);
        chk(op_active, 0, "frozen select");
        ce = 1;
        tick(4);
        chk(op_active, 1, "select after enable");
        sef_master_i.desel();
        tick(4);
        chk(op_active, 0, "deselect after enable");
        $display("done: enable");
        close_out();
    end
endmodule
